//--- hw/rapb_page_builder.sv
// attribute page builder: register store and 512-byte page streamer
`timescale 1ns/1ps

module rapb_page_builder #(
  parameter bit FREEFALL = 1'b0,
  parameter logic [15:0] REV_WORD = 16'h00A5 // arbitrary value
) (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire logic page_req_in,
  input wire logic page_ready_in,
  output logic page_valid_out,
  output logic [7:0] page_data_out,
  output logic page_last_out
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic id_ok(input logic [7:0] id);
    case (id)
      8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h08, 8'h09, 8'h0A,
      8'h0C, 8'hBF, 8'hC0, 8'hC1, 8'hC2, 8'hC3, 8'hC4, 8'hC5, 8'hC6,
      8'hC7, 8'hDF: id_ok = 1'b1;
      8'hA0, 8'hFE: id_ok = FREEFALL;
      default: id_ok = 1'b0;
    endcase
  endfunction

  // performance and error-rate attributes may run above 100
  function automatic logic id_ext(input logic [7:0] id);
    case (id)
      8'h01, 8'h02, 8'h07, 8'h08, 8'hBF: id_ext = 1'b1;
      default: id_ext = 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] norm_val(input logic [7:0] id,
                                          input logic [7:0] v);
    logic [7:0] top;
    top = id_ext(id) ? rapb_pkg::VAL_MAX_EXT : rapb_pkg::VAL_MAX_STD;
    if (v < rapb_pkg::VAL_MIN || v == 8'hFF) begin
      norm_val = rapb_pkg::VAL_INVALID;
    end else if (v == rapb_pkg::VAL_INVALID) begin
      norm_val = v;
    end else if (v > top) begin
      norm_val = top;
    end else begin
      norm_val = v;
    end
  endfunction

  // reserved entry bytes must never read zero
  function automatic logic [7:0] nz(input logic [7:0] b);
    nz = (b == 8'h00) ? 8'h01 : b;
  endfunction

  function automatic logic legal_off(input logic [6:0] c);
    legal_off = (c == 7'h00) || (c == 7'h02) || (c == 7'h04) ||
                (c == 7'h05) || (c == 7'h06);
  endfunction

  function automatic logic [7:0] page_byte(input logic [8:0] a,
                                           input rapb_pkg::rapb_regs_s s);
    logic [8:0] off;
    logic [4:0] idx;
    logic [3:0] sub;
    logic [2:0] k;
    rapb_pkg::rapb_entry_s e;
    off = a - rapb_pkg::OFS_ENT_FIRST;
    idx = 5'(off / 9'd12);
    sub = 4'(off % 9'd12);
    k = 3'(sub - rapb_pkg::EF_RAW_LO);
    e = '0;
    if (idx < 5'(rapb_pkg::NUM_ENT)) begin
      e = s.ent[idx];
    end
    page_byte = 8'h00;
    if (a < rapb_pkg::OFS_ENT_FIRST) begin
      page_byte = a[0] ? REV_WORD[15:8] : REV_WORD[7:0];
    end else if (a < rapb_pkg::OFS_OFF_STAT) begin
      if (id_ok(e.id)) begin
        case (sub)
          rapb_pkg::EF_ID: page_byte = e.id;
          rapb_pkg::EF_FLAGS_LO: page_byte = {2'b00, e.flags};
          rapb_pkg::EF_FLAGS_HI: page_byte = 8'h00;
          rapb_pkg::EF_VALUE: page_byte = e.value;
          rapb_pkg::EF_RSV4: page_byte = nz(e.rsv4);
          rapb_pkg::EF_ZERO: page_byte = 8'h00;
          default: page_byte = nz(e.raw[{k, 3'b000} +: 8]);
        endcase
      end
    end else begin
      case (a)
        rapb_pkg::OFS_OFF_STAT: page_byte = {s.auto_off, s.off_code};
        rapb_pkg::OFS_TEST_STAT: page_byte = {s.result, s.remain};
        rapb_pkg::OFS_OFF_TIME: page_byte = s.off_time[7:0];
        9'h16D: page_byte = s.off_time[15:8];
        rapb_pkg::OFS_SEG_PTR: page_byte = s.seg_ptr;
        rapb_pkg::OFS_OFF_CAP: page_byte = rapb_pkg::OFF_CAP_VAL;
        rapb_pkg::OFS_MON_CAP: page_byte = rapb_pkg::MON_CAP_VAL[7:0];
        9'h171: page_byte = rapb_pkg::MON_CAP_VAL[15:8];
        rapb_pkg::OFS_LOG_CAP: page_byte = rapb_pkg::LOG_CAP_VAL;
        rapb_pkg::OFS_CHECKPT: page_byte = s.checkpt;
        rapb_pkg::OFS_SHORT_T: page_byte = s.short_t;
        rapb_pkg::OFS_EXT_T: page_byte = s.ext_t;
        default: page_byte = 8'h00;
      endcase
    end
  endfunction

  // ****************************************
  // state
  // ****************************************
  rapb_pkg::rapb_regs_s s_reg;
  rapb_pkg::rapb_regs_s s_next;
  logic [4:0] widx;
  logic [7:0] new_sum;

  assign widx = reg_addr_in[6:2];
  assign new_sum = s_reg.sum + s_reg.data;

  always_comb begin
    s_next = s_reg;
    // ****************************************
    // register writes
    // ****************************************
    if (reg_wr_in) begin
      if (reg_addr_in < rapb_pkg::RA_ENT_END) begin
        case (reg_addr_in[1:0])
          2'b00: begin
            s_next.ent[widx].id = reg_wdata_in[7:0];
            s_next.ent[widx].flags = reg_wdata_in[13:8];
            s_next.ent[widx].value =
              norm_val(reg_wdata_in[7:0], reg_wdata_in[23:16]);
          end
          2'b01: s_next.ent[widx].rsv4 = reg_wdata_in[7:0];
          2'b10: s_next.ent[widx].raw[31:0] = reg_wdata_in;
          default: s_next.ent[widx].raw[47:32] = reg_wdata_in[15:0];
        endcase
      end else if (reg_addr_in == rapb_pkg::RA_DYN0) begin
        s_next.auto_off = reg_wdata_in[7];
        if (legal_off(reg_wdata_in[6:0])) begin
          s_next.off_code = reg_wdata_in[6:0];
        end
        // illegal result codes leave the result nibble unchanged
        if (reg_wdata_in[15:12] <= 4'h7 || reg_wdata_in[15:12] == 4'hF) begin
          s_next.result = reg_wdata_in[15:12];
        end
        s_next.remain = (reg_wdata_in[11:8] > rapb_pkg::REMAIN_MAX) ?
                        rapb_pkg::REMAIN_MAX : reg_wdata_in[11:8];
        s_next.off_time = reg_wdata_in[31:16];
      end else if (reg_addr_in == rapb_pkg::RA_DYN1) begin
        s_next.seg_ptr = reg_wdata_in[7:0];
        s_next.checkpt = reg_wdata_in[15:8];
        s_next.short_t = reg_wdata_in[23:16];
        s_next.ext_t = reg_wdata_in[31:24];
      end
    end
    // ****************************************
    // register reads, answered next cycle
    // ****************************************
    s_next.rdata = 32'h0000_0000;
    if (reg_rd_in) begin
      if (reg_addr_in < rapb_pkg::RA_ENT_END) begin
        case (reg_addr_in[1:0])
          2'b00: s_next.rdata = {8'h00, s_reg.ent[widx].value, 2'b00,
                                 s_reg.ent[widx].flags, s_reg.ent[widx].id};
          2'b01: s_next.rdata = {24'h000000, s_reg.ent[widx].rsv4};
          2'b10: s_next.rdata = s_reg.ent[widx].raw[31:0];
          default: s_next.rdata = {16'h0000, s_reg.ent[widx].raw[47:32]};
        endcase
      end else begin
        case (reg_addr_in)
          rapb_pkg::RA_DYN0: s_next.rdata = {s_reg.off_time, s_reg.result,
            s_reg.remain, s_reg.auto_off, s_reg.off_code};
          rapb_pkg::RA_DYN1: s_next.rdata = {s_reg.ext_t, s_reg.short_t,
            s_reg.checkpt, s_reg.seg_ptr};
          rapb_pkg::RA_PAGE: s_next.rdata = {22'h0,
            s_reg.st == rapb_pkg::RAPB_SEND, s_reg.cnt};
          rapb_pkg::RA_LAST_SUM: s_next.rdata = {24'h000000, s_reg.last_sum};
          default: s_next.rdata = 32'h0000_0000;
        endcase
      end
    end
    // ****************************************
    // page streamer
    // ****************************************
    case (s_reg.st)
      rapb_pkg::RAPB_IDLE: begin
        // requests while a page is in flight are ignored
        if (page_req_in) begin
          s_next.st = rapb_pkg::RAPB_SEND;
          s_next.cnt = 9'h000;
          s_next.sum = 8'h00;
          s_next.valid = 1'b1;
          s_next.data = page_byte(9'h000, s_reg);
        end
      end
      rapb_pkg::RAPB_SEND: begin
        if (page_ready_in) begin
          s_next.sum = new_sum;
          if (s_reg.cnt == rapb_pkg::OFS_CSUM) begin
            s_next.st = rapb_pkg::RAPB_IDLE;
            s_next.valid = 1'b0;
            s_next.last_sum = s_reg.data;
          end else begin
            s_next.cnt = s_reg.cnt + 9'h001;
            // sum follows bytes as sent, so live updates stay consistent
            s_next.data = (s_next.cnt == rapb_pkg::OFS_CSUM) ?
              8'(8'h00 - new_sum) : page_byte(s_next.cnt, s_reg);
          end
        end
      end
      default: begin
        s_next.st = rapb_pkg::RAPB_IDLE;
        s_next.valid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_reg <= '0;
      s_reg.st <= rapb_pkg::RAPB_IDLE;
      s_reg.seg_ptr <= rapb_pkg::SEG_PTR_RST;
      for (int i = 0; i < rapb_pkg::NUM_ENT; i++) begin
        s_reg.ent[i].value <= rapb_pkg::VAL_INIT;
      end
    end else begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata_out = s_reg.rdata;
  assign page_valid_out = s_reg.valid;
  assign page_data_out = s_reg.data;
  assign page_last_out = s_reg.valid && (s_reg.cnt == rapb_pkg::OFS_CSUM);

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);

  logic xfer;
  logic [9:0] beats;
  logic [7:0] run_sum;
  logic [8:0] eoff;
  logic [3:0] esub;
  logic in_ent;
  logic [7:0] id_seen;
  assign xfer = page_valid_out && page_ready_in;
  assign eoff = s_reg.cnt - rapb_pkg::OFS_ENT_FIRST;
  assign esub = 4'(eoff % 9'd12);
  assign in_ent = s_reg.cnt >= rapb_pkg::OFS_ENT_FIRST &&
    s_reg.cnt < rapb_pkg::OFS_OFF_STAT;

  // bookkeeping follows accepted bytes, so host stalls cannot skew it
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      beats <= 10'h000;
      run_sum <= 8'h00;
      id_seen <= 8'h00;
    end else if (page_req_in && s_reg.st == rapb_pkg::RAPB_IDLE) begin
      beats <= 10'h000;
      run_sum <= 8'h00;
      id_seen <= 8'h00;
    end else if (xfer) begin
      beats <= beats + 10'h001;
      run_sum <= run_sum + page_data_out;
      if (in_ent && esub == rapb_pkg::EF_ID) begin
        id_seen <= page_data_out;
      end
    end
  end

  a_page_length: assert property (xfer && page_last_out |->
    beats == 10'h1FF) else $error("page not 512 bytes");
  a_start_first: assert property (
    page_req_in && s_reg.st == rapb_pkg::RAPB_IDLE |=>
    page_valid_out && s_reg.cnt == 9'h000) else $error("start missed");
  a_sum_zero: assert property (xfer && page_last_out |->
    8'(run_sum + page_data_out) == 8'h00) else $error("checksum bad");
  a_rev_order: assert property (xfer && s_reg.cnt == 9'h000 |->
    page_data_out == REV_WORD[7:0] ##1 (!page_valid_out ||
    page_data_out == REV_WORD[15:8])) else $error("revision bytes");
  a_cap_const: assert property (xfer &&
    s_reg.cnt == rapb_pkg::OFS_OFF_CAP |-> page_data_out == 8'h5B)
    else $error("off-line capability");
  a_mon_cap: assert property (xfer &&
    s_reg.cnt >= rapb_pkg::OFS_MON_CAP && s_reg.cnt <= rapb_pkg::OFS_LOG_CAP
    |-> page_data_out == (s_reg.cnt == rapb_pkg::OFS_MON_CAP ? 8'h03 :
    s_reg.cnt == rapb_pkg::OFS_LOG_CAP ? 8'h01 : 8'h00))
    else $error("capability bytes");
  a_reserved_zero: assert property (xfer &&
    s_reg.cnt >= rapb_pkg::OFS_RSVD && s_reg.cnt < rapb_pkg::OFS_CSUM |->
    page_data_out == 8'h00) else $error("reserved not zero");
  a_value_legal: assert property (xfer && in_ent &&
    esub == rapb_pkg::EF_VALUE && id_seen != 8'h00 |->
    page_data_out != 8'h00 && page_data_out != 8'hFF)
    else $error("illegal value");
  a_flag_high: assert property (xfer &&
    s_reg.cnt >= rapb_pkg::OFS_ENT_FIRST &&
    s_reg.cnt < rapb_pkg::OFS_OFF_STAT && (esub == rapb_pkg::EF_FLAGS_HI ||
    esub == rapb_pkg::EF_ZERO) |-> page_data_out == 8'h00)
    else $error("flag high byte");
  a_unmapped_read: assert property (reg_rd_in &&
    reg_addr_in > rapb_pkg::RA_LAST_SUM |=> reg_rdata_out == 32'h0)
    else $error("unmapped read");

  c_page_done: cover property (xfer && page_last_out);
  c_stall: cover property (page_valid_out && !page_ready_in ##1 xfer);
  c_entry_write: cover property (reg_wr_in && reg_addr_in == 8'h00);
  c_status_read: cover property (reg_rd_in && reg_addr_in == rapb_pkg::RA_DYN0);

endmodule

//--- hw/rapb_pkg.sv
// constants and types for the reliability attribute page builder
package rapb_pkg;

  // ****************************************
  // page layout
  // ****************************************
  localparam int PAGE_BYTES = 512;
  localparam int NUM_ENT = 30;
  localparam int ENT_BYTES = 12;
  localparam logic [8:0] OFS_REV = 9'h000;
  localparam logic [8:0] OFS_ENT_FIRST = 9'h002;
  localparam logic [8:0] OFS_ENT_LAST = 9'h15E;
  localparam logic [8:0] OFS_OFF_STAT = 9'h16A;
  localparam logic [8:0] OFS_TEST_STAT = 9'h16B;
  localparam logic [8:0] OFS_OFF_TIME = 9'h16C;
  localparam logic [8:0] OFS_SEG_PTR = 9'h16E;
  localparam logic [8:0] OFS_OFF_CAP = 9'h16F;
  localparam logic [8:0] OFS_MON_CAP = 9'h170;
  localparam logic [8:0] OFS_LOG_CAP = 9'h172;
  localparam logic [8:0] OFS_CHECKPT = 9'h173;
  localparam logic [8:0] OFS_SHORT_T = 9'h174;
  localparam logic [8:0] OFS_EXT_T = 9'h175;
  localparam logic [8:0] OFS_RSVD = 9'h176;
  localparam logic [8:0] OFS_VENDOR = 9'h182;
  localparam logic [8:0] OFS_CSUM = 9'h1FF;

  // ****************************************
  // entry field offsets
  // ****************************************
  localparam logic [3:0] EF_ID = 4'h0;
  localparam logic [3:0] EF_FLAGS_LO = 4'h1;
  localparam logic [3:0] EF_FLAGS_HI = 4'h2;
  localparam logic [3:0] EF_VALUE = 4'h3;
  localparam logic [3:0] EF_RSV4 = 4'h4;
  localparam logic [3:0] EF_RAW_LO = 4'h5;
  localparam logic [3:0] EF_ZERO = 4'hB;

  // ****************************************
  // fixed field values
  // ****************************************
  localparam logic [7:0] OFF_CAP_VAL = 8'h5B;
  localparam logic [15:0] MON_CAP_VAL = 16'h0003;
  localparam logic [7:0] LOG_CAP_VAL = 8'h01;
  localparam logic [7:0] VAL_INIT = 8'h64;
  localparam logic [7:0] VAL_MIN = 8'h01;
  localparam logic [7:0] VAL_MAX_STD = 8'h64;
  localparam logic [7:0] VAL_MAX_EXT = 8'hFD;
  localparam logic [7:0] VAL_INVALID = 8'hFE;
  localparam logic [7:0] SEG_PTR_RST = 8'h01;
  localparam logic [3:0] REMAIN_MAX = 4'h9;

  // ****************************************
  // software register map (word index)
  // ****************************************
  localparam logic [7:0] RA_ENT_END = 8'h78;
  localparam logic [7:0] RA_DYN0 = 8'h80;
  localparam logic [7:0] RA_DYN1 = 8'h84;
  localparam logic [7:0] RA_PAGE = 8'h88;
  localparam logic [7:0] RA_LAST_SUM = 8'h8C;

  typedef enum logic [1:0] {
    RAPB_IDLE = 2'b00,
    RAPB_SEND = 2'b01
  } rapb_state_e;

  typedef struct packed {
    logic [7:0] id;
    logic [5:0] flags;
    logic [7:0] value;
    logic [7:0] rsv4;
    logic [47:0] raw;
  } rapb_entry_s;

  typedef struct packed {
    rapb_state_e st;
    logic [8:0] cnt;
    logic [7:0] data;
    logic valid;
    logic [7:0] sum;
    logic [7:0] last_sum;
    logic auto_off;
    logic [6:0] off_code;
    logic [3:0] remain;
    logic [3:0] result;
    logic [15:0] off_time;
    logic [7:0] seg_ptr;
    logic [7:0] checkpt;
    logic [7:0] short_t;
    logic [7:0] ext_t;
    logic [31:0] rdata;
    rapb_entry_s [NUM_ENT-1:0] ent;
  } rapb_regs_s;

endpackage

//--- verif/rapb_host_sink.sv
// host-side model that reads one attribute sector from the page stream
`timescale 1ns/1ps
module rapb_host_sink (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic clear_in,
  input wire logic stall_in,
  input wire logic page_valid_in,
  input wire logic [7:0] page_data_in,
  input wire logic page_last_in,
  output logic page_ready_out
);
  logic [7:0] mem [0:511];
  logic lastf [0:511];
  int cnt;

  // ****************************************
  // sector capture
  // ****************************************
  // whole sector taken one byte per accepted cycle
  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt <= 0;
      page_ready_out <= 1'b0;
    end else begin
      // random stalls prove that offered bytes are held
      page_ready_out <= stall_in ? 1'($urandom % 2) : 1'b1;
      if (clear_in) begin
        cnt <= 0;
      end else if (page_valid_in && page_ready_out) begin
        if (cnt < 512) begin
          mem[cnt] <= page_data_in;
          lastf[cnt] <= page_last_in;
        end
        cnt <= cnt + 1;
      end
    end
  end
endmodule

//--- verif/reliability_attribute_page_builder_tb_top.sv
// self-checking bench for the attribute page builder
`timescale 1ns/1ps
module reliability_attribute_page_builder_tb_top;
  localparam logic [15:0] REV = 16'h5A3C; // arbitrary value
  logic ref_clk_in, arst_n_in, reg_wr_in, reg_rd_in, page_req_in;
  logic page_ready_in, page_valid_out, page_last_out, clr, stall;
  logic [7:0] reg_addr_in, page_data_out;
  logic [31:0] reg_wdata_in, reg_rdata_out, d, d0, d1;
  logic [7:0] e_id [30];
  logic [7:0] e_val [30];
  logic [7:0] e_r4 [30];
  logic [5:0] e_fl [30];
  logic [47:0] e_raw [30];
  logic [7:0] xp [512];
  logic [7:0] ids [16] = '{0, 1, 2, 3, 5, 7, 9, 12, 160, 191, 194, 199,
                           223, 254, 6, 200};
  logic [7:0] sum;
  int fails, n_checks, i, e, k, p;

  rapb_page_builder #(.FREEFALL(1'b0), .REV_WORD(REV)) dut (
    .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .page_req_in(page_req_in),
    .page_ready_in(page_ready_in), .page_valid_out(page_valid_out),
    .page_data_out(page_data_out), .page_last_out(page_last_out));
  rapb_host_sink host (
    .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .clear_in(clr),
    .stall_in(stall), .page_valid_in(page_valid_out),
    .page_data_in(page_data_out), .page_last_in(page_last_out),
    .page_ready_out(page_ready_in));

  // ****************************************
  // expectation helpers
  // ****************************************
  function automatic bit supp(input logic [7:0] id);
    return (id >= 1 && id <= 5) || (id >= 7 && id <= 10) || id == 12 ||
           (id >= 191 && id <= 199) || id == 223;
  endfunction
  function automatic logic [7:0] norm(input logic [7:0] id, v);
    logic [7:0] top;
    top = (id inside {1, 2, 7, 8, 191}) ? 8'hFD : 8'h64;
    if (v == 8'h00 || v >= 8'hFE) return 8'hFE;
    return (v > top) ? top : v;
  endfunction
  function automatic logic [7:0] nz(input logic [7:0] v);
    return (v == 8'h00) ? 8'h01 : v;
  endfunction

  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= v;
    reg_wr_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    #1 v = reg_rdata_out;
  endtask
  task automatic build;
    int b;
    for (b = 0; b < 512; b++) xp[b] = 8'h00;
    xp[0] = REV[7:0];
    xp[1] = REV[15:8];
    for (int n = 0; n < 30; n++) begin
      b = 2 + 12 * n;
      if (supp(e_id[n])) begin
        xp[b] = e_id[n];
        xp[b + 1] = {2'b00, e_fl[n]};
        xp[b + 3] = e_val[n];
        xp[b + 4] = nz(e_r4[n]);
        for (int j = 0; j < 6; j++) xp[b + 5 + j] = nz(e_raw[n][8*j +: 8]);
      end
    end
    {xp[16'h16D], xp[16'h16C], xp[16'h16B], xp[16'h16A]} = d0;
    xp[16'h16E] = d1[7:0];
    xp[16'h16F] = 8'h5B;
    xp[16'h170] = 8'h03;
    xp[16'h172] = 8'h01;
    {xp[16'h175], xp[16'h174], xp[16'h173]} = d1[31:8];
    sum = 8'h00;
    for (b = 0; b < 511; b++) sum = sum + xp[b];
    xp[511] = -sum;
  endtask

  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {arst_n_in, reg_wr_in, reg_rd_in, page_req_in, clr, stall} = '0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 32'h0;
    repeat (4) @(posedge ref_clk_in);
    arst_n_in <= 1'b1;
    void'($urandom(43));
    rd(8'h00, d);
    check("reset entry", d, 32'h00640000);
    rd(8'h84, d);
    check("reset dyn1", d, 32'h00000001);
    rd(8'hFC, d);
    check("unmapped", d, 32'h0);
    $display("test reset done");
    for (i = 0; i < 16; i++) begin
      e = (i < 8) ? 8'h0 : $urandom;
      d0 = {8'h00, (i < 8) ? 8'h00 : 8'($urandom), 2'b00, 6'($urandom),
            ids[i]};
      if (i < 8) d0[23:16] = (i == 0) ? 8'hFF : 8'h60 + 8'(i * 32);
      wr(8'h04, d0);
      rd(8'h04, d);
      d0[23:16] = norm(ids[i], d0[23:16]);
      check("value norm", d, d0);
    end
    $display("test normalise done");
    wr(8'h80, {16'h1234, 4'hF, 4'h3, 1'b1, 7'd2});
    wr(8'h80, {16'h5678, 4'h8, 4'hC, 1'b0, 7'd3});
    rd(8'h80, d);
    check("dyn refuse", d, {16'h5678, 4'hF, 4'h9, 1'b0, 7'd2});
    for (i = 0; i < 9; i++) begin
      d0 = {16'h0, (i == 8) ? 4'hF : 4'(i), 4'(i), 1'(i), 7'(i % 7)};
      if (d0[6:0] inside {1, 3}) d0[6:0] = 7'd6;
      wr(8'h80, d0);
      rd(8'h80, d);
      check("dyn codes", d, d0);
    end
    $display("test status codes done");
    for (p = 0; p < 2; p++) begin
      stall <= p[0];
      for (e = 0; e < 30; e++) begin
        e_id[e] = ids[$urandom % 16];
        e_fl[e] = $urandom;
        e_r4[e] = ($urandom % 3 == 0) ? 8'h00 : 8'($urandom);
        e_raw[e] = {16'($urandom), 24'($urandom), 8'h00};
        d = {8'h00, 8'($urandom), 2'b00, e_fl[e], e_id[e]};
        e_val[e] = norm(e_id[e], d[23:16]);
        wr(8'(4 * e), d);
        wr(8'(4 * e + 1), {24'h0, e_r4[e]});
        wr(8'(4 * e + 2), e_raw[e][31:0]);
        wr(8'(4 * e + 3), {16'h0, e_raw[e][47:32]});
      end
      d0 = {16'($urandom), 4'hF, 4'($urandom % 10), 1'(p), 7'd4};
      d1 = $urandom;
      wr(8'h80, d0);
      wr(8'h84, d1);
      build();
      @(posedge ref_clk_in);
      clr <= 1'b1;
      page_req_in <= 1'b1;
      @(posedge ref_clk_in);
      clr <= 1'b0;
      page_req_in <= 1'b0;
      repeat (50) @(posedge ref_clk_in);
      page_req_in <= 1'b1;
      @(posedge ref_clk_in);
      page_req_in <= 1'b0;
      rd(8'h88, d);
      check("busy", d[9], 1'b1);
      for (k = 0; k < 4000 && host.cnt < 512; k++) @(posedge ref_clk_in);
      if (host.cnt < 512) begin
        fails++;
        break;
      end
      repeat (8) @(posedge ref_clk_in);
      #1 check("byte count", host.cnt, 512);
      check("idle valid", page_valid_out, 1'b0);
      sum = 8'h00;
      for (i = 0; i < 512; i++) begin
        sum = sum + host.mem[i];
        check("last flag", host.lastf[i], i == 511);
      end
      check("page sum", sum, 8'h00);
      for (i = 0; i < 2; i++) check("rev", host.mem[i], xp[i]);
      for (i = 2; i < 362; i++) check("entry", host.mem[i], xp[i]);
      for (i = 362; i < 367; i++) check("dyn", host.mem[i], xp[i]);
      check("off cap", host.mem[16'h16F], 8'h5B);
      for (i = 368; i < 371; i++) check("caps", host.mem[i], xp[i]);
      for (i = 371; i < 374; i++) check("times", host.mem[i], xp[i]);
      for (i = 374; i < 511; i++) check("zero", host.mem[i], 8'h00);
      check("csum", host.mem[511], xp[511]);
      rd(8'h8C, d);
      check("csum reg", d[7:0], xp[511]);
      rd(8'h88, d);
      check("page reg", d, 32'h000001FF);
      $display("test page %0d done", p);
    end
    wrap_up();
  end
endmodule
